// ===== wdk_pkg.sv
// Constants shared by the watchdog with key lock
`default_nettype none
package wdk_pkg;
   // Register addresses on the special function register bus
   localparam logic [7:0] KEY_ADDR = 8'h97;
   localparam logic [7:0] CTRL_ADDR = 8'h9F;
   // Control register field positions
   localparam int ENABLE_BIT = 7;
   localparam int RESTART_BIT = 5;
   localparam int SELECT_MSB = 2;
   localparam int SELECT_LSB = 0;
   // Reset values
   localparam logic [7:0] KEY_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   // Key values of the unlock and lock sequences
   localparam logic [7:0] KEY_FIRST = 8'h1E;
   localparam logic [7:0] KEY_SECOND = 8'hE1;
   // Counter and timing figures
   localparam int COUNT_WIDTH = 16;
   localparam logic [16:0] DIVIDER_BASE = 17'h00080;
   localparam int RC_NOMINAL_KHZ = 250;
   localparam int SHORTEST_PERIOD_US = 2048;
   localparam int LONGEST_PERIOD_US = 262144;
   localparam int SHORTEST_PERIOD_TICKS = SHORTEST_PERIOD_US * RC_NOMINAL_KHZ / 1000;
   // Key lock states
   typedef enum logic [1:0] {
      wdk_locked, wdk_locked_first, wdk_open, wdk_open_first
   } wdk_lock_state_type;
endpackage
`default_nettype wire

// ===== wdk_key_lock.sv
// Key sequence detector that grants and revokes control register write access
`default_nettype none
module wdk_key_lock (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Key register writes
   input wire logic key_write,
   input wire logic [7:0] key_value,
   // Write access state
   output logic unlocked
);
   wdk_pkg::wdk_lock_state_type state;
   wdk_pkg::wdk_lock_state_type next_state;

   // Next state of the key sequence
   always_comb begin
      next_state = state;
      if (key_write) begin
         case (state)
            wdk_pkg::wdk_locked: begin
               if (key_value == wdk_pkg::KEY_FIRST) next_state = wdk_pkg::wdk_locked_first;
            end
            wdk_pkg::wdk_locked_first: begin
               if (key_value == wdk_pkg::KEY_SECOND) begin
                  next_state = wdk_pkg::wdk_open;
               end else if (key_value == wdk_pkg::KEY_FIRST) begin
                  next_state = wdk_pkg::wdk_locked_first;
               end else begin
                  next_state = wdk_pkg::wdk_locked;
               end
            end
            wdk_pkg::wdk_open: begin
               if (key_value == wdk_pkg::KEY_SECOND) next_state = wdk_pkg::wdk_open_first;
            end
            wdk_pkg::wdk_open_first: begin
               if (key_value == wdk_pkg::KEY_FIRST) begin
                  next_state = wdk_pkg::wdk_locked;
               end else if (key_value == wdk_pkg::KEY_SECOND) begin
                  next_state = wdk_pkg::wdk_open_first;
               end else begin
                  next_state = wdk_pkg::wdk_open;
               end
            end
            default: begin
               next_state = wdk_pkg::wdk_locked;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state <= wdk_pkg::wdk_locked;
         unlocked <= 1'b0;
      end else begin
         state <= next_state;
         unlocked <= (next_state == wdk_pkg::wdk_open) || (next_state == wdk_pkg::wdk_open_first);
      end
   end
endmodule
`default_nettype wire

// ===== wdk_watchdog.sv
// Watchdog timer with key-locked control register
// Summary of operation
// - A 16-bit up-counter overflows and then requests a whole-chip reset.
// - The counter advances on the independent roughly 250 kHz RC oscillator.
// - Control writes only take effect after key writes 1Eh then E1h.
// - Key writes E1h then 1Eh return the control register to read-only.
// - Control bit 7 enables counting on the RC oscillator.
// - Writing 1 to control bit 5 zeroes and restarts the counter.
// - Any reset, external or watchdog, clears the enable bit.
// - A watchdog overflow sets the reset-cause flag.
// - Select codes 000 to 111 pick dividers 128 down to 1.
// - Overflow periods double per code, 2.048 ms to 262.144 ms.
// - A watchdog reset restarts the program like a power-on reset.
`default_nettype none
module wdk_watchdog (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Oscillator input from the RC oscillator pin
   input wire logic rc_osc_clock,
   // Special function register bus
   input wire logic [7:0] sfr_address,
   input wire logic sfr_write,
   input wire logic [7:0] sfr_write_data,
   output logic [7:0] sfr_read_data,
   // Reset cause flag clear from the system configuration register
   input wire logic cause_flag_clear,
   // Outputs to the reset controller and system configuration
   output logic chip_reset_request,
   output logic watchdog_reset_cause_flag
);
   // Counter step for a timeout select code
   function automatic logic [16:0] step_for_select(input logic [2:0] select);
      step_for_select = wdk_pkg::DIVIDER_BASE >> select;
   endfunction

   logic rc_meta;
   logic rc_sync;
   logic rc_last;
   logic [7:0] watchdog_unlock_key;
   logic watchdog_run_enable;
   logic [2:0] timeout_select;
   logic restart_pending;
   logic [15:0] count;
   logic unlocked;
   logic rc_tick;
   logic [16:0] sum;
   logic overflow;
   logic key_write;
   logic ctrl_write;
   logic [7:0] next_key;
   logic next_enable;
   logic [2:0] next_select;
   logic next_restart;
   logic [15:0] next_count;
   logic next_reset_request;
   logic next_cause_flag;
   logic [7:0] next_read_data;

   // Key sequence detector
   wdk_key_lock key_lock (
      .clock(clock),
      .reset(reset),
      .key_write(key_write),
      .key_value(sfr_write_data),
      .unlocked(unlocked)
   );

   // Address decode and oscillator edge detection
   assign key_write = sfr_write && (sfr_address == wdk_pkg::KEY_ADDR);
   assign ctrl_write = sfr_write && (sfr_address == wdk_pkg::CTRL_ADDR) && unlocked;
   assign rc_tick = rc_sync && !rc_last;
   assign sum = {1'b0, count} + step_for_select(timeout_select);
   assign overflow = watchdog_run_enable && rc_tick && !restart_pending && sum[16];

   // Next values of the register file, counter and reset outputs
   always_comb begin
      next_key = watchdog_unlock_key;
      next_enable = watchdog_run_enable;
      next_select = timeout_select;
      next_restart = 1'b0;
      next_count = count;
      next_reset_request = overflow;
      next_cause_flag = watchdog_reset_cause_flag;
      if (key_write) begin
         next_key = sfr_write_data;
      end
      if (ctrl_write) begin
         next_enable = sfr_write_data[wdk_pkg::ENABLE_BIT];
         next_select = sfr_write_data[wdk_pkg::SELECT_MSB:wdk_pkg::SELECT_LSB];
         next_restart = sfr_write_data[wdk_pkg::RESTART_BIT];
      end
      if (!watchdog_run_enable || restart_pending) begin
         next_count = wdk_pkg::COUNT_RESET;
      end else if (rc_tick) begin
         next_count = sum[15:0];
      end
      if (cause_flag_clear) begin
         next_cause_flag = 1'b0;
      end
      if (overflow) begin
         next_enable = 1'b0;
         next_count = wdk_pkg::COUNT_RESET;
         next_cause_flag = 1'b1;
      end
      next_read_data = 8'h00;
      if (sfr_address == wdk_pkg::KEY_ADDR) begin
         next_read_data = next_key;
      end else if (sfr_address == wdk_pkg::CTRL_ADDR) begin
         next_read_data[wdk_pkg::ENABLE_BIT] = next_enable;
         next_read_data[wdk_pkg::SELECT_MSB:wdk_pkg::SELECT_LSB] = next_select;
      end
   end

   // Registers; the oscillator pin passes two flip-flops first
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rc_meta <= 1'b0;
         rc_sync <= 1'b0;
         rc_last <= 1'b0;
         watchdog_unlock_key <= wdk_pkg::KEY_RESET;
         watchdog_run_enable <= wdk_pkg::CTRL_RESET[wdk_pkg::ENABLE_BIT];
         timeout_select <= wdk_pkg::CTRL_RESET[wdk_pkg::SELECT_MSB:wdk_pkg::SELECT_LSB];
         restart_pending <= 1'b0;
         count <= wdk_pkg::COUNT_RESET;
         chip_reset_request <= 1'b0;
         watchdog_reset_cause_flag <= 1'b0;
         sfr_read_data <= 8'h00;
      end else begin
         rc_meta <= rc_osc_clock;
         rc_sync <= rc_meta;
         rc_last <= rc_sync;
         watchdog_unlock_key <= next_key;
         watchdog_run_enable <= next_enable;
         timeout_select <= next_select;
         restart_pending <= next_restart;
         count <= next_count;
         chip_reset_request <= next_reset_request;
         watchdog_reset_cause_flag <= next_cause_flag;
         sfr_read_data <= next_read_data;
      end
   end

   // Checks on the watchdog behaviour
   default clocking check_clock @(posedge clock);
   endclocking
   default disable iff (reset);

   sequence key_lock_pair;
      unlocked && key_write && sfr_write_data == wdk_pkg::KEY_SECOND
      ##1 key_write && sfr_write_data == wdk_pkg::KEY_FIRST;
   endsequence

   sequence counting_tick;
      watchdog_run_enable && rc_tick && !restart_pending && !overflow;
   endsequence

   // Unlock pair written back to back while locked
   sequence key_unlock_pair;
      !unlocked && key_write && sfr_write_data == wdk_pkg::KEY_FIRST
      ##1 key_write && sfr_write_data == wdk_pkg::KEY_SECOND;
   endsequence

   overflow_resets_a: assert property (overflow |=> chip_reset_request)
      else $error("overflow did not request a chip reset");
   count_on_tick_a: assert property (
      watchdog_run_enable && !restart_pending && !rc_tick |=> count == $past(count))
      else $error("counter moved without an oscillator edge");
   locked_write_a: assert property (
      sfr_write && sfr_address == wdk_pkg::CTRL_ADDR && !unlocked && !overflow
      |=> watchdog_run_enable == $past(watchdog_run_enable)
          && timeout_select == $past(timeout_select))
      else $error("locked control register changed");
   relock_pair_a: assert property (key_lock_pair |=> !unlocked)
      else $error("lock key pair did not revoke write access");
   count_step_a: assert property (
      counting_tick |=> count == $past(count) + 16'($past(step_for_select(timeout_select))))
      else $error("counter step does not match the timeout select");
   restart_zeroes_a: assert property (restart_pending |=> count == wdk_pkg::COUNT_RESET)
      else $error("restart did not zero the counter");
   enable_drop_a: assert property (overflow |=> !watchdog_run_enable ##1 !chip_reset_request)
      else $error("enable survived a watchdog reset");
   cause_flag_a: assert property (overflow |=> watchdog_reset_cause_flag)
      else $error("reset cause flag not set on overflow");
   unused_bits_a: assert property (
      $past(sfr_address) == wdk_pkg::CTRL_ADDR |-> sfr_read_data[6:3] == 4'h0)
      else $error("unused or restart control bits read non-zero");

   // Key lock, register and reset output checks
   unlock_pair_a: assert property (key_unlock_pair |=> unlocked)
      else $error("unlock key pair did not grant write access");
   key_breaks_a: assert property (
      key_write && sfr_write_data != wdk_pkg::KEY_FIRST
      && sfr_write_data != wdk_pkg::KEY_SECOND |=> unlocked == $past(unlocked))
      else $error("stray key value changed write access");
   control_lands_a: assert property (
      ctrl_write && !overflow
      |=> watchdog_run_enable == $past(sfr_write_data[wdk_pkg::ENABLE_BIT])
          && timeout_select == $past(sfr_write_data[wdk_pkg::SELECT_MSB:wdk_pkg::SELECT_LSB]))
      else $error("unlocked control write did not land");
   restart_once_a: assert property (
      restart_pending && !ctrl_write |=> !restart_pending)
      else $error("restart strobe did not clear itself");
   idle_zero_a: assert property (
      !watchdog_run_enable |=> count == wdk_pkg::COUNT_RESET)
      else $error("counter not held at zero while disabled");
   request_pulse_a: assert property (chip_reset_request |=> !chip_reset_request)
      else $error("chip reset request held longer than one cycle");
   request_cause_a: assert property (chip_reset_request |-> $past(overflow))
      else $error("chip reset request without an overflow");
   flag_hold_a: assert property (
      !overflow && !cause_flag_clear
      |=> watchdog_reset_cause_flag == $past(watchdog_reset_cause_flag))
      else $error("reset cause flag changed without an event");
   flag_clear_a: assert property (
      cause_flag_clear && !overflow |=> !watchdog_reset_cause_flag)
      else $error("reset cause flag ignored a clear");
endmodule
`default_nettype wire

// ===== wdk_watchdog_tb.sv
// Self-checking bench for the watchdog with key lock
`default_nettype none
module wdk_watchdog_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] key_a = wdk_pkg::KEY_ADDR;
   localparam logic [7:0] ctl_a = wdk_pkg::CTRL_ADDR;
   logic clock, reset, rc_osc_clock, sfr_write, cause_flag_clear;
   logic [7:0] sfr_address, sfr_write_data, sfr_read_data, key_model, ctrl_model;
   logic chip_reset_request, watchdog_reset_cause_flag;
   int fail_count, tests_run, seed, ticks, mark, step, s;
   bit open;
   wdk_watchdog DUT (.clock(clock), .reset(reset), .rc_osc_clock(rc_osc_clock),
      .sfr_address(sfr_address), .sfr_write(sfr_write), .sfr_write_data(sfr_write_data),
      .sfr_read_data(sfr_read_data), .cause_flag_clear(cause_flag_clear),
      .chip_reset_request(chip_reset_request),
      .watchdog_reset_cause_flag(watchdog_reset_cause_flag));
   // System clock and free-running oscillator, with a tick count for periods
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      rc_osc_clock = 1'b0;
      ticks = 0;
      forever #32 rc_osc_clock = ~rc_osc_clock;
   end
   always @(posedge rc_osc_clock) ticks = ticks + 1;
   // Compare and count
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // Model of one register write: key sequence, write access and stored values
   task automatic model_wr(input logic [7:0] addr, input logic [7:0] data);
      if (addr == ctl_a && open) ctrl_model = data & 8'h87;
      if (addr == key_a) begin
         key_model = data;
         if (data == (open ? wdk_pkg::KEY_SECOND : wdk_pkg::KEY_FIRST)) step = 1;
         else if (step == 1 && data == (open ? wdk_pkg::KEY_FIRST : wdk_pkg::KEY_SECOND)) begin
            open = !open;
            step = 0;
         end else step = 0;
      end
   endtask
   // Register write with an idle cycle after it
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clock);
      sfr_address = addr;
      sfr_write_data = data;
      sfr_write = 1'b1;
      @(negedge clock);
      sfr_write = 1'b0;
      model_wr(addr, data);
   endtask
   // Two key writes back to back, the strobe held high between them
   task automatic key_pair(input logic [7:0] first, input logic [7:0] second);
      @(negedge clock);
      sfr_address = key_a;
      sfr_write_data = first;
      sfr_write = 1'b1;
      @(negedge clock);
      sfr_write_data = second;
      model_wr(key_a, first);
      @(negedge clock);
      sfr_write = 1'b0;
      model_wr(key_a, second);
   endtask
   // Register read compared with the model
   task automatic rd(input logic [7:0] addr, input string what);
      @(negedge clock);
      sfr_address = addr;
      @(negedge clock);
      check(what, addr == key_a ? key_model : addr == ctl_a ? ctrl_model : 8'h00, sfr_read_data);
   endtask
   // Wait for the reset request and judge the period in oscillator ticks
   task automatic overflow(input int want);
      int n;
      n = 0;
      while (chip_reset_request !== 1'b1 && n < 20000) begin
         @(negedge clock);
         n++;
      end
      check("reset request", 1, chip_reset_request);
      n = ticks - mark - want;
      check("period ok", 1, n >= -2 && n <= 2);
      check("cause flag", 1, watchdog_reset_cause_flag);
      ctrl_model[7] = 1'b0;
      rd(ctl_a, "enable after overflow");
      @(negedge clock);
      cause_flag_clear = 1'b1;
      @(negedge clock);
      cause_flag_clear = 1'b0;
      check("flag cleared", 0, watchdog_reset_cause_flag);
   endtask
   task automatic results;
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Hang guard, well beyond the expected run
   initial begin
      #600000;
      fail_count++;
      results();
   end
   // Main sequence
   initial begin
      seed = 32'hb393;
      fail_count = 0;
      tests_run = 0;
      open = 0;
      step = 0;
      key_model = wdk_pkg::KEY_RESET;
      ctrl_model = wdk_pkg::CTRL_RESET;
      reset = 1'b1;
      sfr_address = 8'h00;
      sfr_write = 1'b0;
      sfr_write_data = 8'h00;
      cause_flag_clear = 1'b0;
      repeat (8) @(negedge clock);
      reset = 1'b0;
      rd(ctl_a, "control reset");
      rd(key_a, "key reset");
      wr(ctl_a, 8'h87);
      rd(ctl_a, "locked control");
      wr(key_a, 8'h1E);
      wr(key_a, 8'h55);
      wr(key_a, 8'hE1);
      wr(ctl_a, 8'h87);
      rd(ctl_a, "broken key");
      $display("Test done: lock");
      key_pair(8'h1E, 8'hE1);
      for (s = 0; s < 8; s++) begin
         wr(ctl_a, 8'h78 | s[7:0]);
         rd(ctl_a, "select code");
      end
      $display("Test done: fields");
      for (s = 0; s < 3; s++) begin
         wr(ctl_a, 8'h80 | s[7:0]);
         mark = ticks;
         overflow(65536 / (128 >> s));
      end
      $display("Test done: periods");
      wr(ctl_a, 8'h80);
      mark = ticks;
      wait (ticks >= mark + 300);
      wr(ctl_a, 8'hA0);
      mark = ticks;
      overflow(512);
      $display("Test done: restart");
      key_pair(8'hE1, 8'h1E);
      wr(ctl_a, 8'h87);
      rd(ctl_a, "relocked control");
      wr(key_a, 8'h1E);
      wr(key_a, 8'hE1);
      wr(ctl_a, 8'h81);
      @(negedge clock);
      reset = 1'b1;
      @(negedge clock);
      reset = 1'b0;
      open = 0;
      step = 0;
      key_model = wdk_pkg::KEY_RESET;
      ctrl_model = wdk_pkg::CTRL_RESET;
      rd(ctl_a, "enable after reset");
      $display("Test done: reset");
      repeat (12) begin
         s = $random(seed);
         wr({4'h9, s[3:0]}, s[14:8] & 8'h7F);
         rd({4'h9, s[3:0]}, "random access");
      end
      $display("Test done: random");
      results();
   end
endmodule
`default_nettype wire
